// ==== core/fcu_pkg.sv ====
// fcu_pkg: constants shared by the frame check sequence unit.
// Assumes: 8-bit registers on a 32-bit APB, one word per register.
package fcu_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h04;
  localparam logic [5:0] IDX_STATUS = 6'h06;
  localparam logic [5:0] IDX_FB_PTR = 6'h08;
  localparam logic [5:0] IDX_FB_DATA = 6'h09;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h0a;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h0b;
  localparam logic [5:0] IDX_TX_LEN = 6'h0c;
  // Field positions and reset values
  localparam int CTRL_AUTO_BIT = 5;
  localparam int STATUS_VALID_BIT = 7;
  localparam int RXSTAT_VALID_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h20;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [6:0] TX_LEN_RESET = 7'h03;
  // Interrupt status bits
  localparam int IRQ_W = 5;
  localparam int IRQ_FRAME_END = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_ACK_REJECT = 2;
  localparam int IRQ_FRAME_DROP = 3;
  localparam int IRQ_TX_REFUSED = 4;
  // Check value arithmetic, bit-reversed form for lsb-first feeding
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  // Frame length limits
  localparam logic [6:0] LEN_MIN_TX = 7'h03;
  localparam logic [6:0] LEN_MIN_RX = 7'h02;
  localparam logic [6:0] LEN_FCS = 7'h02;
  // Transmit sequencer states
  typedef enum logic {FCU_TX_IDLE, FCU_TX_SEND} fcu_tx_state_t;
endpackage : fcu_pkg

// ==== core/fcu_ifs.sv ====
// fcu_ifs: carriers between the unit's own modules.
// Assumes: all signals belong to the single MCLK domain.
`timescale 1ns/1ps
// Check engine control and result
interface fcu_crc_if;
  logic clr;
  logic step;
  logic [7:0] data;
  logic [15:0] rem;
  modport engine(input clr, step, data, output rem);
  modport user(output clr, step, data, input rem);
endinterface : fcu_crc_if

// Register access strobes from the bus front end
interface fcu_reg_if;
  logic [5:0] idx;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;
  modport front(output idx, wr, rd, wdata, input rdata, hit);
  modport regs(input idx, wr, rd, wdata, output rdata, hit);
endinterface : fcu_reg_if

// ==== core/fcu_crc16.sv ====
// fcu_crc16: octet-wide 16-bit check remainder engine.
// Assumes: octets arrive lsb first in air order, one per step.
`timescale 1ns/1ps
module fcu_crc16
  import fcu_pkg::*;
#(
  parameter logic [15:0] POLY = CRC_POLY_REFL
) (
  input wire logic clk,
  input wire logic rst_b,
  fcu_crc_if.engine crc
);
  logic [15:0] base;

  // Eight serial division steps, lsb of the octet first
  function automatic logic [15:0] step8(input logic [15:0] r, input logic [7:0] d);
    logic [15:0] c;
    logic fb;
    c = r;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ d[i];
      c = {1'b0, c[15:1]} ^ (fb ? POLY : 16'h0000);
    end
    return c;
  endfunction : step8

  // Clear and step in one cycle: the octet is the first of a frame
  assign base = crc.clr ? CRC_INIT : crc.rem;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crc.rem <= CRC_INIT;
    end else begin
      crc.rem <= crc.step ? step8(base, crc.data) : base;
    end
  end
endmodule : fcu_crc16

// ==== core/fcu_apb_front.sv ====
// fcu_apb_front: APB slave, one wait-free access phase per transfer.
// Assumes: master holds request until pready; 8-bit registers in low bits.
`timescale 1ns/1ps
module fcu_apb_front
  import fcu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  fcu_reg_if.front regs
);
  logic setup;
  logic good;
  logic done;

  assign setup = psel && !penable;
  assign good = regs.hit && (paddr[1:0] == 2'h0);
  assign done = psel && penable && pready;
  assign regs.idx = paddr[7:2];
  assign regs.wdata = pwdata[7:0];
  assign regs.wr = done && pwrite && !pslverr;
  assign regs.rd = done && !pwrite && !pslverr;

  // Answer is registered in setup so prdata, pready and pslverr leave a flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !good;
      if (setup) begin
        prdata <= (!pwrite && good) ? {24'h00_0000, regs.rdata} : 32'h0000_0000;
      end
    end
  end
endmodule : fcu_apb_front

// ==== core/fcu_top.sv ====
// fcu_top: frame check sequence unit with frame buffer and registers.
// Assumes: radio strobes synchronous to MCLK; host uses APB on MCLK.
//
// Function
// - Check value is a 16-bit remainder, generator x^16+x^12+x^5+1.
// - All octets after the length field are covered; result ends the frame.
// - Check field is the remainder of message times x^16 over generator.
// - Reference acknowledgement value reproduced, first bits sent first.
// - Transmit generation for non-ack frames only while the auto-generation bit is one.
// - For length 3..127, check over first N-2 octets replaces last two.
// - Acknowledgement frames always get a generated check value.
// - Host may omit last two octets; full declared length is still sent.
// - Every received frame of two or more octets is checked.
// - Valid bit set or cleared exactly when frame end is signalled.
// - Valid result held stable until the next frame end.
// - Result also written to bit 7 of the receive status byte.
// - Extended mode drops bad frames without frame end signalling.
// - Retry mode rejects acknowledgements with a bad check value.
// - Auto-generation enable is control bit 5 at 0x04, reset one.
// - Read-only valid bit 7 at 0x06, one valid, reset zero.
// - Auto-generation control obeyed in basic and extended modes.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module fcu_top
  import fcu_pkg::*;
#(
  parameter int FB_AW = 7
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  input wire logic TX_START,
  input wire logic TX_IS_ACK,
  input wire logic TX_READY,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  output logic TX_LAST,
  input wire logic RX_SHR,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_END,
  input wire logic EXT_MODE,
  input wire logic ARET_ACK,
  output logic [7:0] RX_STATUS,
  output logic FRAME_END,
  output logic FRAME_DROP,
  output logic ACK_ACCEPT,
  output logic ACK_REJECT
);
  // The buffer must hold a largest frame; the pointer register is one
  // byte wide, so a deeper buffer could not be addressed by software
  if (FB_AW < 7 || FB_AW > 8) begin : g_chk
    $error("FB_AW must be 7 or 8");
  end

  fcu_reg_if regs();
  fcu_crc_if tx_crc();
  fcu_crc_if rx_crc();

  // Register state
  logic [7:0] transceiver_control_one;
  logic crc_valid;
  logic [6:0] tx_len;
  logic [FB_AW-1:0] fb_ptr;
  logic [7:0] fbuf [2**FB_AW];
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] next_irq_stat;

  // Transmit state
  fcu_tx_state_t tx_state;
  logic [6:0] tx_idx;
  logic [6:0] tx_n;
  logic tx_auto;
  logic tx_take;
  logic tx_load;
  logic tx_fin;
  logic tx_in_fcs;
  logic [7:0] tx_octet;
  logic tx_go;
  logic tx_refuse;
  logic start_auto;

  // Receive state
  logic [6:0] rx_cnt;
  logic rx_end_d;
  logic rx_ok;

  fcu_apb_front u_apb (
    .clk(MCLK),
    .rst_b(RST_B),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .regs(regs.front)
  );

  fcu_crc16 u_tx_crc (
    .clk(MCLK),
    .rst_b(RST_B),
    .crc(tx_crc.engine)
  );

  fcu_crc16 u_rx_crc (
    .clk(MCLK),
    .rst_b(RST_B),
    .crc(rx_crc.engine)
  );

  // Read decode; unmapped indices raise the bus error
  // Reads here are free of side effects: the status clear waits for the
  // access edge, after the bus front end has captured the value
  always_comb begin
    regs.hit = 1'b1;
    regs.rdata = 8'h00;
    case (regs.idx)
      IDX_CTRL: regs.rdata = transceiver_control_one;
      IDX_STATUS: regs.rdata = STATUS_RESET | 8'(crc_valid) << STATUS_VALID_BIT;
      IDX_FB_PTR: regs.rdata = 8'(fb_ptr);
      IDX_FB_DATA: regs.rdata = fbuf[fb_ptr];
      IDX_IRQ_STAT: regs.rdata = 8'(irq_stat);
      IDX_IRQ_MASK: regs.rdata = 8'(irq_mask);
      IDX_TX_LEN: regs.rdata = {1'b0, tx_len};
      default: regs.hit = 1'b0;
    endcase
  end

  // Control register; bit 5 steers transmit generation
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      transceiver_control_one <= CTRL_RESET;
    end else if (regs.wr && regs.idx == IDX_CTRL) begin
      transceiver_control_one <= regs.wdata;
    end
  end

  // Transmit length, mask and buffer pointer
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_len <= TX_LEN_RESET;
      irq_mask <= '0;
      fb_ptr <= '0;
    end else if (regs.wr) begin
      if (regs.idx == IDX_TX_LEN) begin
        tx_len <= regs.wdata[6:0];
      end
      if (regs.idx == IDX_IRQ_MASK) begin
        irq_mask <= regs.wdata[IRQ_W-1:0];
      end
      if (regs.idx == IDX_FB_PTR) begin
        fb_ptr <= regs.wdata[FB_AW-1:0];
      end else if (regs.idx == IDX_FB_DATA) begin
        fb_ptr <= fb_ptr + 1'b1;
      end
    end
  end

  // Frame buffer; host fills it, the transmitter only reads
  always_ff @(posedge MCLK) begin
    if (regs.wr && regs.idx == IDX_FB_DATA) begin
      fbuf[fb_ptr] <= regs.wdata;
    end
  end

  // Sticky status; a read clears only the bits it returned, so an
  // event landing between setup and access is kept, and set beats clear
  always_comb begin
    next_irq_stat = irq_stat;
    if (regs.rd && regs.idx == IDX_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~PRDATA[IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | ev;
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_stat <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      IRQ <= |(next_irq_stat & irq_mask);
    end
  end

  // Acknowledgements always use generation, other frames follow bit 5
  assign start_auto = TX_IS_ACK || transceiver_control_one[CTRL_AUTO_BIT];
  // Zero length, or auto length below three, cannot be served
  // A refused start leaves no trace but the refusal flag
  assign tx_refuse = TX_START && tx_state == FCU_TX_IDLE &&
                     (tx_len == 7'h00 || (start_auto && tx_len < LEN_MIN_TX));
  assign tx_go = TX_START && tx_state == FCU_TX_IDLE && !tx_refuse;

  // An octet moves when the output stage is empty or being taken
  assign tx_take = tx_state == FCU_TX_SEND && (!TX_VALID || TX_READY);
  assign tx_load = tx_take && tx_idx != tx_n;
  assign tx_fin = tx_take && tx_idx == tx_n;
  assign tx_in_fcs = tx_auto && tx_idx >= tx_n - LEN_FCS;

  // Last two octets come from the remainder, highest coefficient first
  always_comb begin
    tx_octet = fbuf[FB_AW'(tx_idx)];
    if (tx_in_fcs) begin
      tx_octet = (tx_idx == tx_n - LEN_FCS) ? tx_crc.rem[7:0] : tx_crc.rem[15:8];
    end
  end

  // Engine sees only buffer octets; the step lands one cycle before
  // the first check octet can be loaded, so the remainder is settled
  assign tx_crc.clr = tx_go;
  assign tx_crc.step = tx_load && !tx_in_fcs;
  assign tx_crc.data = tx_octet;

  // Transmit sequencer
  // Length and generation choice are latched at start; later register
  // writes only affect the next frame
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_state <= FCU_TX_IDLE;
      tx_idx <= 7'h00;
      tx_n <= 7'h00;
      tx_auto <= 1'b0;
    end else begin
      case (tx_state)
        FCU_TX_IDLE: begin
          if (tx_go) begin
            tx_state <= FCU_TX_SEND;
            tx_idx <= 7'h00;
            tx_n <= tx_len;
            tx_auto <= start_auto;
          end
        end
        FCU_TX_SEND: begin
          if (tx_load) begin
            tx_idx <= tx_idx + 7'h01;
          end else if (tx_fin) begin
            tx_state <= FCU_TX_IDLE;
          end
        end
        default: tx_state <= FCU_TX_IDLE;
      endcase
    end
  end

  // Output stage toward the modulator
  // A stalled sink keeps the octet and its last mark unchanged
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_DATA <= 8'h00;
      TX_VALID <= 1'b0;
      TX_LAST <= 1'b0;
    end else if (tx_load) begin
      TX_DATA <= tx_octet;
      TX_VALID <= 1'b1;
      TX_LAST <= tx_idx == tx_n - 7'h01;
    end else if (TX_VALID && TX_READY) begin
      TX_VALID <= 1'b0;
      TX_LAST <= 1'b0;
    end
  end

  // Receive engine restarts on every sync header
  assign rx_crc.clr = RX_SHR;
  assign rx_crc.step = RX_VALID;
  assign rx_crc.data = RX_DATA;

  // Octet count; saturates so overlong frames do not wrap
  // Frames shorter than two octets carry no check field: reported invalid
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_cnt <= 7'h00;
      rx_end_d <= 1'b0;
    end else begin
      rx_end_d <= RX_END;
      if (RX_SHR) begin
        rx_cnt <= RX_VALID ? 7'h01 : 7'h00;
      end else if (RX_VALID && rx_cnt != 7'h7f) begin
        rx_cnt <= rx_cnt + 7'h01;
      end
    end
  end

  // Running over data and check field leaves zero when intact; the
  // verdict waits one cycle so a last octet beside RX_END is counted
  assign rx_ok = rx_cnt >= LEN_MIN_RX && rx_crc.rem == CRC_INIT;

  // Frame verdict and its effects
  // Retry acknowledgements are judged on their own lines, so a bad ack
  // never moves the valid bit software is reading; validity ends at the
  // next reported frame end rather than at the next sync header
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      crc_valid <= 1'b0;
      RX_STATUS <= 8'h00;
      FRAME_END <= 1'b0;
      FRAME_DROP <= 1'b0;
      ACK_ACCEPT <= 1'b0;
      ACK_REJECT <= 1'b0;
    end else begin
      FRAME_END <= 1'b0;
      FRAME_DROP <= 1'b0;
      ACK_ACCEPT <= 1'b0;
      ACK_REJECT <= 1'b0;
      if (rx_end_d) begin
        if (ARET_ACK) begin
          ACK_ACCEPT <= rx_ok;
          ACK_REJECT <= !rx_ok;
        end else if (EXT_MODE && !rx_ok) begin
          FRAME_DROP <= 1'b1;
        end else begin
          // Valid bit otherwise untouched until the next frame end
          crc_valid <= rx_ok;
          FRAME_END <= 1'b1;
          RX_STATUS <= 8'(rx_ok) << RXSTAT_VALID_BIT;
        end
      end
    end
  end

  // Events feeding the sticky status
  // The three receive terms mirror the end, drop and reject branches above, so flags and pulses agree
  always_comb begin
    ev = '0;
    ev[IRQ_FRAME_END] = rx_end_d && !ARET_ACK && !(EXT_MODE && !rx_ok);
    ev[IRQ_TX_DONE] = tx_fin;
    ev[IRQ_ACK_REJECT] = rx_end_d && ARET_ACK && !rx_ok;
    ev[IRQ_FRAME_DROP] = rx_end_d && !ARET_ACK && EXT_MODE && !rx_ok;
    ev[IRQ_TX_REFUSED] = tx_refuse;
  end
endmodule : fcu_top

// ==== bench/fcu_monitor.sv ====
// fcu_mon: port-level timing checks of the frame check unit.
// Assumes: bound into fcu_top; one MCLK domain.
`timescale 1ns/1ps
module fcu_mon
  import fcu_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic TX_READY,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_LAST,
  input wire logic RX_END,
  input wire logic [7:0] RX_STATUS,
  input wire logic FRAME_END,
  input wire logic FRAME_DROP,
  input wire logic ACK_ACCEPT,
  input wire logic ACK_REJECT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // Bus answers exactly one cycle after setup
  a_pready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  a_pready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_write_no_data: assert property (PREADY && PWRITE |-> PRDATA == 32'h0)
    else $error("read data on a write");
  // Every frame end gets a verdict two cycles later
  a_rx_answer: assert property (RX_END |-> ##2 (FRAME_END || FRAME_DROP || ACK_ACCEPT || ACK_REJECT))
    else $error("no verdict after frame end");
  a_end_cause: assert property (FRAME_END |-> $past(RX_END, 2))
    else $error("frame end without cause");
  // Result only moves together with the frame end pulse
  a_status_hold: assert property (!$stable(RX_STATUS) |-> FRAME_END)
    else $error("receive status moved alone");
  a_status_spare: assert property (RX_STATUS[6:0] == 7'h0)
    else $error("receive status spare bits set");
  a_drop_alone: assert property (FRAME_DROP |-> !FRAME_END && !ACK_ACCEPT && !ACK_REJECT)
    else $error("dropped frame also reported");
  a_ack_verdict: assert property (ACK_ACCEPT || ACK_REJECT |-> !(ACK_ACCEPT && ACK_REJECT) && !FRAME_END)
    else $error("ack verdict ambiguous");
  // Stalled octet must not change under the sink
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
    else $error("octet changed while stalled");
  a_tx_last_ends: assert property (TX_VALID && TX_READY && TX_LAST |=> !TX_VALID)
    else $error("octets after last");
endmodule : fcu_mon

bind fcu_top fcu_mon u_mon (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .TX_READY(TX_READY), .TX_DATA(TX_DATA),
  .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .RX_END(RX_END), .RX_STATUS(RX_STATUS),
  .FRAME_END(FRAME_END), .FRAME_DROP(FRAME_DROP), .ACK_ACCEPT(ACK_ACCEPT),
  .ACK_REJECT(ACK_REJECT));

// ==== bench/fcu_radio_model.sv ====
// fcu_radio_model: radio side, octet sink for transmit, source for receive.
// Assumes: strobes synchronous to the unit clock.
`timescale 1ns/1ps
module fcu_radio_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic rx_shr = 1'b0,
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_data = 8'h00,
  output logic rx_end = 1'b0
);
  logic [7:0] got [0:127];
  int n_got = 0;
  logic [1:0] phase;
  // Stalling sink is ready one cycle in four
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end
  assign tx_ready = !stall || (phase == 2'h3);
  // Capture of transmitted octets
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got[n_got] <= tx_data;
      n_got <= n_got + 1;
    end
  end
  task automatic clear;
    n_got = 0;
  endtask : clear
  // Sync header with first octet; end with last; data line inverted when idle
  task automatic send(input logic [7:0] q [$]);
    @(posedge clk);
    rx_shr <= 1'b1;
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_data <= q[i];
      rx_end <= (i == q.size() - 1);
      @(posedge clk);
      rx_shr <= 1'b0;
    end
    rx_valid <= 1'b0;
    rx_end <= 1'b0;
    rx_data <= ~rx_data;
  endtask : send
endmodule : fcu_radio_model

// ==== bench/test_frame_check_sequence_unit.sv ====
// test_frame_check_sequence_unit: self-checking bench of the check unit.
// Assumes: fcu_top with APB registers and a radio model on the far side.
`timescale 1ns/1ps
module test_frame_check_sequence_unit;
  import fcu_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, irq, tx_ready, tx_valid, tx_last, rx_shr, rx_valid, rx_end;
  logic tx_start = 1'b0, tx_is_ack = 1'b0, ext_mode = 1'b0, aret_ack = 1'b0, stall = 1'b0;
  logic frame_end, frame_drop, ack_accept, ack_reject, errv;
  logic [7:0] tx_data, rx_data, rx_status;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  fcu_top u_dut (.MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq), .TX_START(tx_start), .TX_IS_ACK(tx_is_ack), .TX_READY(tx_ready),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_LAST(tx_last), .RX_SHR(rx_shr),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_END(rx_end), .EXT_MODE(ext_mode),
    .ARET_ACK(aret_ack), .RX_STATUS(rx_status), .FRAME_END(frame_end),
    .FRAME_DROP(frame_drop), .ACK_ACCEPT(ack_accept), .ACK_REJECT(ack_reject));
  fcu_radio_model u_radio (.clk(mclk), .rst_b(rst_b), .stall(stall), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_shr(rx_shr), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end));
  // Clock and hang guard
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Reference remainder, zero start, lsb first
  function automatic logic [15:0] crc_of(input logic [7:0] q [$]);
    logic [15:0] r;
    r = 16'h0000;
    foreach (q[i]) for (int b = 0; b < 8; b++) r = (r[0] ^ q[i][b]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
    return r;
  endfunction : crc_of
  // One APB transfer; waits for ready, only the hang guard ends a wait
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(what, rdv, {24'h0, exp});
  endtask : rdchk
  task automatic load(input logic [7:0] q [$]);
    apb(1'b1, IDX_FB_PTR, 8'h00);
    foreach (q[i]) apb(1'b1, IDX_FB_DATA, q[i]);
  endtask : load
  task automatic send_tx(input logic [6:0] len, input logic ack);
    apb(1'b1, IDX_TX_LEN, {1'b0, len});
    u_radio.clear();
    @(posedge mclk);
    tx_start <= 1'b1;
    tx_is_ack <= ack;
    @(posedge mclk);
    tx_start <= 1'b0;
    tx_is_ack <= 1'b0;
    for (int n = 0; n < 2000 && u_radio.n_got < len; n++) @(posedge mclk);
    repeat (3) @(posedge mclk);
  endtask : send_tx
  task automatic got_chk(input logic [7:0] e [$]);
    check("tx count", 32'(u_radio.n_got), 32'(e.size()));
    foreach (e[i]) check("tx octet", {24'h0, u_radio.got[i]}, {24'h0, e[i]});
  endtask : got_chk
  // Reset values, read-only place, unmapped place
  task automatic t_regs;
    rdchk("ctrl reset", IDX_CTRL, 8'h20);
    rdchk("status reset", IDX_STATUS, 8'h00);
    apb(1'b1, IDX_STATUS, 8'hff);
    rdchk("status read only", IDX_STATUS, 8'h00);
    apb(1'b0, 6'h3f, 8'h00);
    check("unmapped error", {31'h0, errv}, 32'h1);
  endtask : t_regs
  // Reference ack header with short buffer fill, then generation on and off
  task automatic t_tx;
    logic [7:0] q [$];
    logic [15:0] c;
    stall <= 1'b1;
    load('{8'h02, 8'h00, 8'h6a});
    send_tx(7'd5, 1'b0);
    got_chk('{8'h02, 8'h00, 8'h6a, 8'he4, 8'h79});
    apb(1'b1, IDX_CTRL, 8'h00);
    q = '{8'h11, 8'h22, 8'h33, 8'h44};
    load(q);
    send_tx(7'd4, 1'b0);
    got_chk(q);
    c = crc_of('{8'h11, 8'h22});
    q = '{8'h11, 8'h22, c[7:0], c[15:8]};
    ext_mode <= 1'b1;
    send_tx(7'd4, 1'b1);
    got_chk(q);
    ext_mode <= 1'b0;
    apb(1'b1, IDX_CTRL, 8'h20);
    send_tx(7'd4, 1'b0);
    got_chk(q);
    stall <= 1'b0;
  endtask : t_tx
  // Done flag of the sends above; auto length two is refused and sends nothing
  task automatic t_refuse;
    rdchk("tx done flag", IDX_IRQ_STAT, 8'h02);
    apb(1'b1, IDX_TX_LEN, 8'h02);
    u_radio.clear();
    @(posedge mclk);
    tx_start <= 1'b1;
    @(posedge mclk);
    tx_start <= 1'b0;
    repeat (4) @(posedge mclk);
    check("refused count", 32'(u_radio.n_got), 32'h0);
    rdchk("refused flag", IDX_IRQ_STAT, 8'h10);
  endtask : t_refuse
  // One received frame; events are {end, drop, accept, reject}
  task automatic rx_case(input logic [7:0] q [$], input logic ext, input logic aret,
                         input logic [3:0] ev, input logic ok);
    logic [3:0] seen;
    seen = 4'h0;
    ext_mode <= ext;
    aret_ack <= aret;
    u_radio.send(q);
    repeat (4) begin
      @(posedge mclk);
      seen = seen | {frame_end, frame_drop, ack_accept, ack_reject};
    end
    check("rx events", {28'h0, seen}, {28'h0, ev});
    check("rx status", {24'h0, rx_status}, {24'h0, ok, 7'h0});
    rdchk("valid bit", IDX_STATUS, {ok, 7'h0});
  endtask : rx_case
  task automatic t_rx;
    logic [7:0] g [$];
    logic [7:0] b [$];
    g = '{8'h02, 8'h00, 8'h6a, 8'he4, 8'h79};
    b = g;
    b[4] = 8'h78;
    rx_case(g, 1'b0, 1'b0, 4'h8, 1'b1);
    rx_case(b, 1'b1, 1'b0, 4'h4, 1'b1);
    rx_case(b, 1'b0, 1'b0, 4'h8, 1'b0);
    rx_case(g, 1'b1, 1'b0, 4'h8, 1'b1);
    rx_case(b, 1'b0, 1'b1, 4'h1, 1'b1);
    rx_case(g, 1'b0, 1'b1, 4'h2, 1'b1);
    rx_case('{8'h55}, 1'b0, 1'b0, 4'h8, 1'b0);
    rx_case('{8'h00, 8'h00}, 1'b0, 1'b0, 4'h8, 1'b1);
  endtask : t_rx
  // Masked drop stays quiet, unmasked end raises the line, read clears
  task automatic t_irq;
    apb(1'b0, IDX_IRQ_STAT, 8'h00);
    apb(1'b1, IDX_IRQ_MASK, 8'h01);
    rx_case('{8'h01, 8'h02, 8'h03}, 1'b1, 1'b0, 4'h4, 1'b1);
    check("irq masked", {31'h0, irq}, 32'h0);
    rx_case('{8'h00, 8'h00}, 1'b0, 1'b0, 4'h8, 1'b1);
    check("irq raised", {31'h0, irq}, 32'h1);
    rdchk("irq status", IDX_IRQ_STAT, 8'h09);
    repeat (2) @(posedge mclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask : t_irq
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_tx();
    t_refuse();
    t_rx();
    t_irq();
    tally_and_finish();
  end
endmodule : test_frame_check_sequence_unit
